// file: hdl/tcmo_pkg.sv
// Constants and types of the 16-bit timer with compare output unit.
// Assumes a single 100 MHz clock and AXI4-Lite with 32-bit data.
package tcmo_pkg;

  localparam int unsigned NCH = 2;
  localparam int unsigned AW = 8;

  // Register byte offsets
  localparam logic [AW-1:0] OFS_CONTROL = 8'h00;
  localparam logic [AW-1:0] OFS_COUNTER = 8'h04;
  localparam logic [AW-1:0] OFS_COMPARE_A = 8'h08;
  localparam logic [AW-1:0] OFS_COMPARE_B = 8'h0c;
  localparam logic [AW-1:0] OFS_CAPTURE = 8'h10;
  localparam logic [AW-1:0] OFS_FLAGS = 8'h14;
  localparam logic [AW-1:0] OFS_FORCE = 8'h18;
  localparam logic [AW-1:0] OFS_PORT = 8'h1c;

  // Control register fields
  localparam int unsigned CTL_MODE_LSB = 0;
  localparam int unsigned CTL_ACT_LSB = 4;
  // Flags register fields
  localparam int unsigned FLG_OVERFLOW = 0;
  localparam int unsigned FLG_COMPARE_LSB = 1;
  localparam int unsigned FLG_CAPTURE = 3;
  // Port register fields
  localparam int unsigned PRT_DATA_LSB = 0;
  localparam int unsigned PRT_DIR_LSB = 2;
  localparam int unsigned PRT_STATE_LSB = 4;
  localparam int unsigned PRT_PIN_LSB = 6;

  // Waveform mode values handled here
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
  localparam logic [3:0] MODE_CTC_CAPT = 4'hc;

  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Reset values
  localparam logic [15:0] RST_WORD16 = 16'h0000;
  localparam logic [31:0] RST_WORD32 = 32'h0000_0000;

  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_CLEAR = 2'b10,
    ACT_SET = 2'b11
  } tcmo_action_e;

  typedef struct packed {
    logic [15:0] counter;
    logic [NCH-1:0][15:0] compare;
    logic [15:0] capture;
    logic [3:0] mode;
    logic [NCH-1:0][1:0] action;
    logic overflow;
    logic [NCH-1:0] compareFlag;
    logic captureFlag;
    logic block;
    logic [NCH-1:0] outState;
    logic [NCH-1:0] portData;
    logic [NCH-1:0] pinDir;
    logic awHeld;
    logic [AW-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } tcmo_state_s;

endpackage

// file: hdl/tcmo_timer16.sv
// 16-bit timer: Normal and clear-on-match counting, compare output unit.
// Assumes timerTick is a one-cycle enable from an outside prescaler and
// that software reaches the registers over AXI4-Lite.
//
// How it works
// [R1] Reset clears each compare output state
// [R2] Nonzero action field overrides port data
// [R3] Direction bit alone enables the pin driver
// [R4] Output state settable before driver enabled
// [R5] Action field never touches capture logic
// [R6] Action zero leaves state unchanged on match
// [R7] New action applies from next match
// [R8] Force strobe applies action in non-PWM modes
// [R9] Count sequence depends on mode only
// [R10] Action selects toggle, clear or set
// [R11] Mode 0 counts up, wraps at max
// [R12] Normal mode sets overflow at zero
// [R13] Counter writable any time in Normal
// [R14] Mode 4/12 clears on A/capture match
// [R15] Top match sets compare A/capture flag
// [R16] Unbuffered top; missed match runs to max
// [R17] Action 1 toggles channel A per match
// [R18] Toggle period is 2*N*(1+compare A)
// [R19] Clear-on-match sets overflow at max wrap
// [R20] Compare flag set on matching timer tick
// [R21] Force updates only the output state
// [R22] Counter write blocks next tick's matches
// [R23] No action: pin follows port data bit
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps

module tcmo_timer16 (
  // System
  input wire logic clk,
  input wire logic rst,
  // Timer clock enable from prescaler
  input wire logic timerTick,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Compare output pins, channel 0 is A
  input wire logic [1:0] pinIn,
  output logic [1:0] pinOut,
  output logic [1:0] pinOe
);

  tcmo_pkg::tcmo_state_s s;
  tcmo_pkg::tcmo_state_s next_s;

  logic [1:0] match;
  logic nonPwm;
  logic ctcA;
  logic ctcCapt;
  logic topMatch;

  assign nonPwm = (s.mode == tcmo_pkg::MODE_NORMAL) ||
                  (s.mode == tcmo_pkg::MODE_CTC_CMPA) ||
                  (s.mode == tcmo_pkg::MODE_CTC_CAPT);
  assign ctcA = (s.mode == tcmo_pkg::MODE_CTC_CMPA);
  assign ctcCapt = (s.mode == tcmo_pkg::MODE_CTC_CAPT);

  // Equality only: a top written below the count is simply passed by,
  // so the counter runs on to max and wraps first. see [R16]
  assign topMatch = timerTick && !s.block &&
    ((ctcA && s.counter == s.compare[0]) ||
     (ctcCapt && s.counter == s.capture)); // see [R14] see [R22]

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gCh
      // Continuous compare, suppressed after a counter write. see [R20]
      assign match[g] = timerTick && !s.block &&
                        (s.counter == s.compare[g]); // see [R22]
      // Override takes the data path only; direction stays with the
      // port bit, so the state can be prepared first. see [R3] see [R4]
      assign pinOut[g] = (s.action[g] != 2'b00) ? s.outState[g]
                                                : s.portData[g]; // see [R2] see [R23]
      assign pinOe[g] = s.pinDir[g]; // see [R3]
    end
  endgenerate

  assign s_axi_awready = !s.awHeld && !s.bValid;
  assign s_axi_wready = !s.wHeld && !s.bValid;
  assign s_axi_bvalid = s.bValid;
  assign s_axi_bresp = s.bResp;
  assign s_axi_arready = !s.rValid;
  assign s_axi_rvalid = s.rValid;
  assign s_axi_rdata = s.rData;
  assign s_axi_rresp = s.rResp;

  function automatic logic apply_action(input logic [1:0] act,
                                        input logic cur);
    logic res;
    res = cur;
    case (act)
      tcmo_pkg::ACT_NONE: res = cur; // see [R6]
      tcmo_pkg::ACT_TOGGLE: res = !cur; // see [R17] see [R18]
      tcmo_pkg::ACT_CLEAR: res = 1'b0;
      tcmo_pkg::ACT_SET: res = 1'b1;
      default: res = cur;
    endcase
    return res; // see [R10]
  endfunction

  always_comb begin
    logic [31:0] mask;
    logic [31:0] wd;
    logic doWrite;
    logic okW;
    logic [1:0] forceHit;
    logic [15:0] nextCount;
    logic [1:0] flagClr;
    logic ovfClr;
    logic capClr;
    logic [31:0] rd;
    logic okR;
    mask = {{8{s.wStrb[3]}}, {8{s.wStrb[2]}},
            {8{s.wStrb[1]}}, {8{s.wStrb[0]}}};
    wd = s.wData & mask;
    doWrite = s.awHeld && s.wHeld;
    okW = 1'b1;
    forceHit = 2'b00;
    flagClr = 2'b00;
    ovfClr = 1'b0;
    capClr = 1'b0;
    rd = tcmo_pkg::RST_WORD32;
    okR = 1'b1;
    next_s = s;

    // Write channels are taken independently, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.wHeld = 1'b1;
      next_s.wData = s_axi_wdata;
      next_s.wStrb = s_axi_wstrb;
    end
    if (s.bValid && s_axi_bready) begin
      next_s.bValid = 1'b0;
    end

    // Counting: sequence chosen by the mode field alone. see [R9]
    nextCount = s.counter;
    if (timerTick && nonPwm) begin
      if (topMatch) begin
        nextCount = tcmo_pkg::COUNT_BOTTOM; // see [R14]
      end else begin
        nextCount = s.counter + 16'h0001; // see [R11]
      end
    end
    next_s.counter = nextCount;
    // The block lasts until the next timer tick, running or not
    if (timerTick) begin
      next_s.block = 1'b0;
    end

    // Register writes
    if (doWrite) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld = 1'b0;
      next_s.bValid = 1'b1;
      case (s.awAddr)
        tcmo_pkg::OFS_CONTROL: begin
          next_s.mode = (s.mode & ~mask[3:0]) | wd[3:0];
          // Takes effect from the next match only. see [R7]
          next_s.action = (s.action & ~mask[7:4]) | wd[7:4];
        end
        tcmo_pkg::OFS_COUNTER: begin
          // Accepted at any time; wins over the same-cycle increment.
          next_s.counter = (nextCount & ~mask[15:0]) | wd[15:0]; // see [R13]
          next_s.block = 1'b1; // see [R22]
        end
        tcmo_pkg::OFS_COMPARE_A: begin
          next_s.compare[0] = (s.compare[0] & ~mask[15:0]) | wd[15:0];
        end
        tcmo_pkg::OFS_COMPARE_B: begin
          next_s.compare[1] = (s.compare[1] & ~mask[15:0]) | wd[15:0];
        end
        tcmo_pkg::OFS_CAPTURE: begin
          next_s.capture = (s.capture & ~mask[15:0]) | wd[15:0];
        end
        tcmo_pkg::OFS_FLAGS: begin
          ovfClr = wd[tcmo_pkg::FLG_OVERFLOW];
          flagClr = wd[tcmo_pkg::FLG_COMPARE_LSB +: 2];
          capClr = wd[tcmo_pkg::FLG_CAPTURE];
        end
        tcmo_pkg::OFS_FORCE: begin
          // PWM modes ignore the strobe. see [R8]
          if (nonPwm) begin
            forceHit = wd[1:0];
          end
        end
        tcmo_pkg::OFS_PORT: begin
          next_s.portData = (s.portData & ~mask[1:0]) | wd[1:0];
          next_s.pinDir = (s.pinDir & ~mask[3:2]) | wd[3:2];
        end
        default: okW = 1'b0;
      endcase
      next_s.bResp = okW ? tcmo_pkg::RESP_OKAY : tcmo_pkg::RESP_DECERR;
    end

    // Flags: software clear first, so a same-cycle hardware set wins
    if (ovfClr) begin
      next_s.overflow = 1'b0;
    end
    if (capClr) begin
      next_s.captureFlag = 1'b0;
    end
    next_s.compareFlag = s.compareFlag & ~flagClr;
    if (timerTick && nonPwm && s.counter == tcmo_pkg::COUNT_MAX) begin
      next_s.overflow = 1'b1; // see [R12] see [R19]
    end
    next_s.compareFlag = next_s.compareFlag | match; // see [R20]
    if (topMatch && ctcCapt) begin
      next_s.captureFlag = 1'b1; // see [R15]
    end

    // Output states: real matches, then forced ones; a force never
    // touches the flags or the counter. see [R21]
    for (int i = 0; i < 2; i++) begin
      if (match[i] && nonPwm) begin
        next_s.outState[i] = apply_action(s.action[i], s.outState[i]);
      end
      if (forceHit[i]) begin
        next_s.outState[i] = apply_action(s.action[i],
                                          next_s.outState[i]); // see [R8]
      end
    end

    // Read channel
    if (s.rValid && s_axi_rready) begin
      next_s.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      case (s_axi_araddr)
        tcmo_pkg::OFS_CONTROL: begin
          rd[tcmo_pkg::CTL_MODE_LSB +: 4] = s.mode;
          rd[tcmo_pkg::CTL_ACT_LSB +: 4] = s.action;
        end
        tcmo_pkg::OFS_COUNTER: rd[15:0] = s.counter;
        tcmo_pkg::OFS_COMPARE_A: rd[15:0] = s.compare[0];
        tcmo_pkg::OFS_COMPARE_B: rd[15:0] = s.compare[1];
        tcmo_pkg::OFS_CAPTURE: rd[15:0] = s.capture;
        tcmo_pkg::OFS_FLAGS: begin
          rd[tcmo_pkg::FLG_OVERFLOW] = s.overflow;
          rd[tcmo_pkg::FLG_COMPARE_LSB +: 2] = s.compareFlag;
          rd[tcmo_pkg::FLG_CAPTURE] = s.captureFlag;
        end
        tcmo_pkg::OFS_FORCE: rd = tcmo_pkg::RST_WORD32;
        tcmo_pkg::OFS_PORT: begin
          rd[tcmo_pkg::PRT_DATA_LSB +: 2] = s.portData;
          rd[tcmo_pkg::PRT_DIR_LSB +: 2] = s.pinDir;
          rd[tcmo_pkg::PRT_STATE_LSB +: 2] = s.outState;
          rd[tcmo_pkg::PRT_PIN_LSB +: 2] = pinIn;
        end
        default: okR = 1'b0;
      endcase
      next_s.rValid = 1'b1;
      next_s.rData = rd;
      next_s.rResp = okR ? tcmo_pkg::RESP_OKAY : tcmo_pkg::RESP_DECERR;
    end
  end

  // Capture logic lives outside; the action field feeds none of it. see [R5]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0; // see [R1]
    end else begin
      s <= next_s;
    end
  end

endmodule // tcmo_timer16

// file: sim/tcmo_timer16_properties.sv
// Port assertions for the timer with compare output unit.
// Assumes one clock, clk, and active-high asynchronous reset rst.
`timescale 1ns/1ps

module tcmo_timer16_properties (
  // System
  input wire logic clk,
  input wire logic rst,
  input wire logic timerTick,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic [1:0] pinOut,
  input wire logic [1:0] pinOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  reset_clears_pins_a: assert property (
    $fell(rst) |-> pinOut == 2'b00 && pinOe == 2'b00)
    else $error("pins not cleared by reset");
  write_answer_a: assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  busy_refuse_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answering");
  read_answer_a: assert property (rdTaken |=> s_axi_rvalid)
    else $error("read data late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read data dropped");
  dir_by_write_a: assert property (
    $changed(pinOe) |-> $rose(s_axi_bvalid))
    else $error("pin enable moved without a write");
  pin_cause_a: assert property (
    $changed(pinOut) |-> $past(timerTick) || $rose(s_axi_bvalid))
    else $error("pin moved without tick or write");
endmodule // tcmo_timer16_properties

bind tcmo_timer16 tcmo_timer16_properties tcmo_timer16_properties_i (
  .clk(clk), .rst(rst), .timerTick(timerTick),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pinOut(pinOut), .pinOe(pinOe));

// file: sim/tcmo_pin_load.sv
// Outside circuitry on the two compare pins.
// Assumes no pull resistor, so an undriven pin floats.
`timescale 1ns/1ps

module tcmo_pin_load (
  // System
  input wire logic clk,
  // Pins
  input wire logic [1:0] pinOut,
  input wire logic [1:0] pinOe,
  output logic [1:0] pinIn
);
  logic [1:0] floatLvl = 2'b01;
  // A floating pin wobbles so a stale level never passes for a drive
  always @(posedge clk) floatLvl <= ~floatLvl;
  assign pinIn = (pinOe & pinOut) | (~pinOe & floatLvl);
endmodule // tcmo_pin_load

// file: sim/tcmo_timer16_tb_top.sv
// Self-checking bench for the timer with compare output unit.
// Assumes the pin load model and the port checker are compiled first.
`timescale 1ns/1ps

module tcmo_timer16_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic timerTick = 1'b0;
  logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
  logic [31:0] wData = 32'h0, rd;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
  logic arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp, rs, pinIn, pinOut, pinOe, data, dir, st;
  logic [3:0] act;
  int errors = 0, check_count = 0, seed = 51513;
  int tickDiv = 0, divCnt = 0, stall = 0, k, n, t, g, h;

  always #5 clk = ~clk;

  tcmo_timer16 tcmo_timer16_i (.clk(clk), .rst(rst), .timerTick(timerTick),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rd), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe));
  tcmo_pin_load tcmo_pin_load_i (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
    .pinIn(pinIn));

  // Prescaler stand-in, active only while tickDiv is nonzero
  always @(posedge clk) begin
    if (tickDiv != 0) begin
      divCnt <= (divCnt + 1 >= tickDiv) ? 0 : divCnt + 1;
      timerTick <= (divCnt == 0);
    end
  end

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic hung(input string what);
    errors++;
    $display("MISMATCH %s expected answer seen none", what);
    tally_and_finish();
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int c;
    c = 0;
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= (stall == 0);
    do begin
      @(posedge clk);
      c++;
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
      if (c >= stall) bReady <= 1'b1;
    end while (!(bValid && bReady) && c < 40);
    rs = bResp;
    bReady <= 1'b0;
    if (!bValid) hung("write response");
  endtask

  task automatic axr(input logic [7:0] a);
    int c;
    c = 0;
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= (stall == 0);
    do begin
      @(posedge clk);
      c++;
      if (arReady) arValid <= 1'b0;
      if (c >= stall) rReady <= 1'b1;
    end while (!(rValid && rReady) && c < 40);
    rs = rResp;
    rReady <= 1'b0;
    if (!rValid) hung("read data");
  endtask

  task automatic pulse(input int m);
    repeat (m) begin
      timerTick <= 1'b1;
      @(posedge clk);
    end
    timerTick <= 1'b0;
    @(posedge clk);
  endtask

  task automatic edgeGap(output int c);
    logic p;
    p = pinOut[0];
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (pinOut[0] === p && c < 200);
    if (c >= 200) hung("toggle");
  endtask

  function automatic logic nextState(input logic [1:0] a, input logic s);
    case (a)
      2'b01: return ~s;
      2'b10: return 1'b0;
      2'b11: return 1'b1;
      default: return s;
    endcase
  endfunction

  function automatic logic [1:0] pinExp(input logic [3:0] a,
                                        input logic [1:0] s, d);
    pinExp[0] = (a[1:0] != 2'b00) ? s[0] : d[0];
    pinExp[1] = (a[3:2] != 2'b00) ? s[1] : d[1];
  endfunction

  initial begin
    st = 2'b00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axr(tcmo_pkg::OFS_PORT);
    chk("port after reset", 32'h0, rd & 32'h3f);
    chk("pin enable after reset", 32'h0, {30'h0, pinOe});
    stall = 3;
    axr(8'h40);
    chk("unmapped read resp", tcmo_pkg::RESP_DECERR, rs);
    chk("unmapped read data", 32'h0, rd);
    axw(8'h40, 32'h1);
    chk("unmapped write resp", tcmo_pkg::RESP_DECERR, rs);
    stall = 0;
    for (t = 0; t < 6; t++) begin
      act = 4'($random(seed));
      data = 2'($random(seed));
      dir = (t == 0) ? 2'b00 : 2'($random(seed));
      if (t == 0) act = 4'hf;
      axw(tcmo_pkg::OFS_PORT, {28'h0, dir, data});
      axw(tcmo_pkg::OFS_CONTROL, {24'h0, act, 4'h0});
      axw(tcmo_pkg::OFS_FORCE, 32'h3);
      st[0] = nextState(act[1:0], st[0]);
      st[1] = nextState(act[3:2], st[1]);
      axr(tcmo_pkg::OFS_PORT);
      chk("output state", st, rd[5:4]);
      chk("pin data", pinExp(act, st, data), pinOut);
      chk("pin enable", dir, pinOe);
      chk("pin readback", pinOut & dir, rd[7:6] & dir);
    end
    axw(tcmo_pkg::OFS_CONTROL, 32'h0);
    axw(tcmo_pkg::OFS_FLAGS, 32'hf);
    axw(tcmo_pkg::OFS_COUNTER, 32'hfffe);
    pulse(2);
    axr(tcmo_pkg::OFS_COUNTER);
    chk("normal wrap", 32'h0, rd);
    axr(tcmo_pkg::OFS_FLAGS);
    chk("normal overflow", 32'h1, rd[0]);
    axw(tcmo_pkg::OFS_COMPARE_B, 32'h5);
    axw(tcmo_pkg::OFS_FLAGS, 32'hf);
    axw(tcmo_pkg::OFS_COUNTER, 32'h5);
    pulse(1);
    axw(tcmo_pkg::OFS_FORCE, 32'h3);
    axr(tcmo_pkg::OFS_FLAGS);
    chk("blocked and forced flags", 32'h0, rd[2:1]);
    axr(tcmo_pkg::OFS_COUNTER);
    chk("count after block", 32'h6, rd);
    axw(tcmo_pkg::OFS_COUNTER, 32'h4);
    pulse(2);
    axr(tcmo_pkg::OFS_FLAGS);
    chk("compare flag", 32'h1, rd[2]);
    axw(tcmo_pkg::OFS_CONTROL, 32'hc);
    axw(tcmo_pkg::OFS_CAPTURE, 32'h3);
    axw(tcmo_pkg::OFS_FLAGS, 32'hf);
    axw(tcmo_pkg::OFS_COUNTER, 32'hfff0);
    pulse(16);
    axr(tcmo_pkg::OFS_COUNTER);
    chk("missed top wrap", 32'h0, rd);
    axr(tcmo_pkg::OFS_FLAGS);
    chk("wrap flags", 32'h1, rd[3:0]);
    pulse(4);
    axr(tcmo_pkg::OFS_COUNTER);
    chk("clear at capture", 32'h0, rd);
    axr(tcmo_pkg::OFS_FLAGS);
    chk("capture flag", 32'h1, rd[3]);
    for (n = 1; n <= 2; n++) begin
      k = ($random(seed) & 7) + 1;
      axw(tcmo_pkg::OFS_CONTROL, 32'h14);
      axw(tcmo_pkg::OFS_COMPARE_A, k);
      axw(tcmo_pkg::OFS_PORT, 32'hc);
      axw(tcmo_pkg::OFS_COUNTER, 32'h0);
      divCnt <= 0;
      tickDiv <= n;
      edgeGap(g);
      edgeGap(g);
      edgeGap(h);
      chk("toggle period", 2 * n * (1 + k), g + h);
      tickDiv <= 0;
      @(posedge clk);
      timerTick <= 1'b0;
      axr(tcmo_pkg::OFS_FLAGS);
      chk("compare A flag", 32'h1, rd[1]);
    end
    tally_and_finish();
  end
endmodule // tcmo_timer16_tb_top
